// ---- rtl/interrupt_source_selector.v ----
`timescale 1ns/1ps
`include "interrupt_source_selector_defines.vh"

// How it works
// [R01] sixteen interrupt lines go to the core, each of fixed rank
// [R02] rank falls with line number; line zero is reset, fifteen lowest
// [R03] lines zero to three are fixed: reset, nmi, two never asserted
// [R04] lines four to fifteen are maskable and each has its own selector
// [R05] two selector registers: high at 0x019C0000, low at 0x019C0004
// [R06] 5-bit fields, three per 16-bit half; low serves 4-9, high 10-15
// [R07] default lines 4-7 take external pins 4-7, codes 00100 to 00111
// [R08] default lines 8 and 9 take dma channels 0 and 1
// [R09] default line 10 takes the sdram refresh timer event, code 00011
// [R10] default lines 11 and 12 take dma channels 2 and 3
// [R11] default 13 host, 14 timer0, 15 timer1
// [R12] a written field routes its source; serial codes 01100-01111, 10001, 10010
// [R13] software never writes reserved codes 10000 or 10011 to 11111
// [R14] external pins 4-7 are edge detected, each edge chosen by a polarity bit
// [R15] reset loads default codes; bits 15 and 31 read zero, ignore writes
module interrupt_source_selector (
  input wire clk,
  input wire rst,
  // axi4-lite slave
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // pins
  input wire nmi_pin,
  input wire [3:0] ext_pin,
  // on-chip event sources, same clock
  input wire host_event,
  input wire timer0_event,
  input wire timer1_event,
  input wire sdram_refresh_event,
  input wire dma_chan0_done,
  input wire dma_chan1_done,
  input wire dma_chan2_done,
  input wire dma_chan3_done,
  input wire serial0_tx_event,
  input wire serial0_rx_event,
  input wire serial1_tx_event,
  input wire serial1_rx_event,
  input wire serial2_tx_event,
  input wire serial2_rx_event,
  // towards the core
  output wire [15:0] cpu_int,
  output wire irq
);

  reg awready_r;
  reg wready_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  reg arready_r;
  reg rvalid_r;
  reg [31:0] rdata_r;
  reg [1:0] rresp_r;
  reg aw_held_r;
  reg w_held_r;
  reg [31:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;

  reg [31:0] irq_select_high_r;
  reg [31:0] irq_select_low_r;
  reg [3:0] ext_edge_polarity_r;
  reg [15:0] status_r;
  reg [15:0] mask_r;
  reg [15:0] cpu_int_r;
  reg irq_r;
  reg reset_line_r;

  reg [3:0] ext_s1_r;
  reg [3:0] ext_s2_r;
  reg [3:0] ext_s3_r;
  reg nmi_s1_r;
  reg nmi_s2_r;
  reg nmi_s3_r;

  wire aw_take;
  wire w_take;
  wire do_write;
  wire ar_take;
  wire [31:0] wmask;
  wire [3:0] ext_rise;
  wire [3:0] ext_fall;
  wire [3:0] ext_pin_event;
  wire nmi_event;
  wire [31:0] sources;
  wire [59:0] fields;
  wire [11:0] mapped_event;
  wire [15:0] line_nxt;
  wire wr_high;
  wire wr_low;
  wire wr_pol;
  wire wr_status;
  wire wr_mask;
  wire wr_hit;
  reg [31:0] rd_nxt;
  reg rd_hit;
  reg [15:0] status_nxt;

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign cpu_int = cpu_int_r;
  assign irq = irq_r;

  // write path: address and data taken in either order, then one write
  assign aw_take = s_axi_awvalid & awready_r;
  assign w_take = s_axi_wvalid & wready_r;
  assign do_write = aw_held_r & w_held_r & ~bvalid_r;
  assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

  assign wr_high = do_write & (awaddr_r == `ADDR_SELECT_HIGH);
  assign wr_low = do_write & (awaddr_r == `ADDR_SELECT_LOW);
  assign wr_pol = do_write & (awaddr_r == `ADDR_EDGE_POLARITY);
  assign wr_status = do_write & (awaddr_r == `ADDR_IRQ_STATUS);
  assign wr_mask = do_write & (awaddr_r == `ADDR_IRQ_MASK);
  assign wr_hit = wr_high | wr_low | wr_pol | wr_status | wr_mask |
                  (do_write & (awaddr_r == `ADDR_LINE_STATE));

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 32'h00000000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else begin
      awready_r <= ~aw_held_r & ~aw_take & ~do_write;
      wready_r <= ~w_held_r & ~w_take & ~do_write;
      if (aw_take) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
      if (do_write) begin
        bvalid_r <= 1'b1;
        // line state is read only: writes are accepted and dropped
        bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_r & s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // software registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_select_high_r <= `SELECT_HIGH_RESET; // see [R09] [R10] [R11] [R15]
      irq_select_low_r <= `SELECT_LOW_RESET; // see [R07] [R08] [R15]
      ext_edge_polarity_r <= `POLARITY_RESET;
      mask_r <= `MASK_RESET;
    end else begin
      if (wr_high) begin
        irq_select_high_r <= ((irq_select_high_r & ~wmask) | (wdata_r & wmask)) &
                             `SELECT_USED_MASK; // see [R05] [R15]
      end
      if (wr_low) begin
        irq_select_low_r <= ((irq_select_low_r & ~wmask) | (wdata_r & wmask)) &
                            `SELECT_USED_MASK; // see [R05] [R15]
      end
      if (wr_pol & wstrb_r[0]) begin
        ext_edge_polarity_r <= wdata_r[3:0]; // see [R14]
      end
      if (wr_mask) begin
        mask_r <= (mask_r & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0]);
      end
    end
  end

  // read path: one read at a time, data held until rready
  assign ar_take = s_axi_arvalid & arready_r;

  always @* begin
    rd_nxt = 32'h00000000;
    rd_hit = 1'b1;
    if (s_axi_araddr == `ADDR_SELECT_HIGH) begin
      rd_nxt = irq_select_high_r;
    end else if (s_axi_araddr == `ADDR_SELECT_LOW) begin
      rd_nxt = irq_select_low_r;
    end else if (s_axi_araddr == `ADDR_EDGE_POLARITY) begin
      rd_nxt = {28'h0000000, ext_edge_polarity_r};
    end else if (s_axi_araddr == `ADDR_IRQ_STATUS) begin
      rd_nxt = {16'h0000, status_r};
    end else if (s_axi_araddr == `ADDR_IRQ_MASK) begin
      rd_nxt = {16'h0000, mask_r};
    end else if (s_axi_araddr == `ADDR_LINE_STATE) begin
      rd_nxt = {16'h0000, cpu_int_r};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `RESP_OKAY;
    end else begin
      arready_r <= ~rvalid_r & ~ar_take;
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_nxt;
        rresp_r <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_r & s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // pin synchronisers; stage three is only the previous sample for edges
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_s1_r <= 4'h0;
      ext_s2_r <= 4'h0;
      ext_s3_r <= 4'h0;
      nmi_s1_r <= 1'b0;
      nmi_s2_r <= 1'b0;
      nmi_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      nmi_s1_r <= nmi_pin;
      nmi_s2_r <= nmi_s1_r;
      nmi_s3_r <= nmi_s2_r;
    end
  end

  assign ext_rise = ext_s2_r & ~ext_s3_r;
  assign ext_fall = ~ext_s2_r & ext_s3_r;
  // polarity bit set picks the falling edge
  assign ext_pin_event = (ext_fall & ext_edge_polarity_r) |
                         (ext_rise & ~ext_edge_polarity_r); // see [R14]
  assign nmi_event = nmi_s2_r & ~nmi_s3_r;

  // source vector indexed by code; reserved codes tied low
  assign sources = {13'h0000, serial2_rx_event, serial2_tx_event, 1'b0,
                    serial1_rx_event, serial1_tx_event, serial0_rx_event, serial0_tx_event,
                    dma_chan3_done, dma_chan2_done, dma_chan1_done, dma_chan0_done,
                    ext_pin_event, sdram_refresh_event, timer1_event, timer0_event,
                    host_event}; // see [R12] [R13]

  // fields of lines 4..15 laid end to end, five bits each
  assign fields = {irq_select_high_r[30:16], irq_select_high_r[14:0],
                   irq_select_low_r[30:16], irq_select_low_r[14:0]}; // see [R06]

  genvar g;
  generate
    for (g = 0; g < `NUM_MAPPED; g = g + 1) begin : line_mux
      event_pick #(
        .NSRC(`NUM_SOURCES),
        .SELW(`FIELD_W)
      ) u_pick (
        .sources(sources),
        .code(fields[g*`FIELD_W +: `FIELD_W]),
        .picked(mapped_event[g])
      ); // see [R04] [R12]
    end
  endgenerate

  // line 0 pulses once after reset release; lines 2 and 3 never assert
  assign line_nxt = {mapped_event, 1'b0, 1'b0, nmi_event, reset_line_r}; // see [R01] [R03]

  // status: hardware set wins over a same-cycle write-one clear
  always @* begin
    status_nxt = status_r;
    if (wr_status) begin
      status_nxt = status_r & ~(wdata_r[15:0] & wmask[15:0]);
    end
    status_nxt = status_nxt | {line_nxt[15:4], 2'b00, line_nxt[1], 1'b0};
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_line_r <= 1'b1;
      cpu_int_r <= 16'h0000;
      status_r <= `STATUS_RESET;
      irq_r <= 1'b0;
    end else begin
      reset_line_r <= 1'b0;
      // bit index is the rank: the core serves lower numbers first
      cpu_int_r <= line_nxt; // see [R02]
      status_r <= status_nxt;
      irq_r <= |(status_nxt & mask_r);
    end
  end

endmodule // interrupt_source_selector

// ---- rtl/interrupt_source_selector_defines.vh ----
`ifndef INTERRUPT_SOURCE_SELECTOR_DEFINES_VH
`define INTERRUPT_SOURCE_SELECTOR_DEFINES_VH

// register byte addresses
`define ADDR_SELECT_HIGH 32'h019C0000
`define ADDR_SELECT_LOW 32'h019C0004
`define ADDR_EDGE_POLARITY 32'h019C0008
`define ADDR_IRQ_STATUS 32'h019C000C
`define ADDR_IRQ_MASK 32'h019C0010
`define ADDR_LINE_STATE 32'h019C0014

// reset values, fields packed low to high in 5-bit codes
`define SELECT_LOW_RESET 32'h250718A4
`define SELECT_HIGH_RESET 32'h08202D43
`define SELECT_USED_MASK 32'h7FFF7FFF
`define POLARITY_RESET 4'h0
`define STATUS_RESET 16'h0000
`define MASK_RESET 16'h0000

// geometry
`define NUM_LINES 16
`define FIRST_MAPPED 4
`define NUM_MAPPED 12
`define FIELD_W 5
`define NUM_SOURCES 32
`define FIELD_LOW_LSB 0
`define FIELD_HIGH_LSB 16
`define FIELD_SPAN 15

// fixed lines
`define LINE_RESET 0
`define LINE_NMI 1
`define LINE_RSVD2 2
`define LINE_RSVD3 3

// source codes
`define SRC_HOST 5'h00
`define SRC_TIMER0 5'h01
`define SRC_TIMER1 5'h02
`define SRC_SDRAM 5'h03
`define SRC_EXT4 5'h04
`define SRC_DMA0 5'h08
`define SRC_SER0_TX 5'h0C
`define SRC_RSVD16 5'h10
`define SRC_SER2_TX 5'h11
`define SRC_SER2_RX 5'h12

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- rtl/event_pick.v ----
`timescale 1ns/1ps

// one programmable line: picks the event whose code sits in the field
module event_pick #(
  parameter NSRC = 32,
  parameter SELW = 5
) (
  input wire [NSRC-1:0] sources,
  input wire [SELW-1:0] code,
  output wire picked
);

  // unconnected codes are tied low in the vector, so reserved codes stay silent
  assign picked = sources[code];

endmodule // event_pick

// ---- testbench/event_source_model.sv ----
`timescale 1ns/1ps
// far side: on-chip sources pulse one cycle, pins are levels that toggle
module event_source_model (
  input wire logic clk,
  input wire logic fire,
  input wire logic [4:0] code,
  output logic [31:0] ev,
  output logic [3:0] pin
);
  initial begin
    ev = 32'h0;
    pin = 4'h0;
  end
  always @(posedge clk) begin
    ev <= 32'h0;
    if (fire && code[4:2] == 3'h1) pin[code[1:0]] <= ~pin[code[1:0]];
    else if (fire) ev[code] <= 1'h1;
  end
endmodule // event_source_model

// ---- testbench/interrupt_source_selector_properties.sv ----
`timescale 1ns/1ps
`include "interrupt_source_selector_defines.vh"
module interrupt_selector_checker (
  input wire logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic s_axi_rvalid, s_axi_rready, irq,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  input wire logic [31:0] s_axi_araddr, s_axi_rdata,
  input wire logic [15:0] cpu_int
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence bad_read;
    s_axi_arvalid && s_axi_arready && !(s_axi_araddr inside {`ADDR_SELECT_HIGH,
      `ADDR_SELECT_LOW, `ADDR_EDGE_POLARITY, `ADDR_IRQ_STATUS, `ADDR_IRQ_MASK,
      `ADDR_LINE_STATE});
  endsequence
  chk_fixed_quiet: assert property (cpu_int[3:2] == 2'h0)
    else $error("reserved line asserted");
  chk_reset_pulse: assert property ($fell(rst) |=> cpu_int[0] ##1 !cpu_int[0])
    else $error("line zero pulse wrong after reset");
  chk_line0_cause: assert property (cpu_int[0] |-> $past(rst, 2))
    else $error("line zero without reset");
  chk_write_answer: assert property (write_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped");
  chk_unmapped_read: assert property (bad_read |=>
    s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read answered");
  chk_aw_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address ready stuck");
endmodule // interrupt_selector_checker
bind interrupt_source_selector interrupt_selector_checker u_chk (.clk, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .irq, .s_axi_bresp, .s_axi_rresp,
  .s_axi_araddr, .s_axi_rdata, .cpu_int);

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`include "interrupt_source_selector_defines.vh"
module testbench;
  logic clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, nmi = 0, fire = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  logic [4:0] fcode = 0;
  wire [31:0] ev, s_axi_rdata;
  wire [3:0] pin;
  wire [15:0] cpu_int;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  int fails = 0, total_checks = 0, cycles = 0;
  logic [4:0] dflt [4:15] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
    5'h03, 5'h0A, 5'h0B, 5'h00, 5'h01, 5'h02};
  logic [4:0] smap [4:9] = '{5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h11, 5'h12};
  always #5 clk = ~clk;
  event_source_model u_src (.clk, .fire, .code(fcode), .ev, .pin);
  interrupt_source_selector u_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nmi_pin(nmi),
    .ext_pin(pin), .host_event(ev[0]), .timer0_event(ev[1]), .timer1_event(ev[2]),
    .sdram_refresh_event(ev[3]), .dma_chan0_done(ev[8]), .dma_chan1_done(ev[9]),
    .dma_chan2_done(ev[10]), .dma_chan3_done(ev[11]), .serial0_tx_event(ev[12]),
    .serial0_rx_event(ev[13]), .serial1_tx_event(ev[14]), .serial1_rx_event(ev[15]),
    .serial2_tx_event(ev[17]), .serial2_rx_event(ev[18]), .cpu_int, .irq);
  task end_sim;
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask
  // ready is raised a cycle late so the hold of each answer is exercised
  task automatic wr(input [31:0] a, input [31:0] d, input [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    forever begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'h1;
    end
    s_axi_bready <= 1'h0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rd(input [31:0] a, input [31:0] exp, input [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    forever begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'h1;
    end
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, exp);
    chk(32'(s_axi_rresp), 32'(er));
  endtask
  // fire one source and expect exactly one line to answer
  task automatic route(input int ln, input [4:0] c);
    int n;
    @(posedge clk);
    if (ln == 1) nmi <= 1'h1;
    else fire <= 1'h1;
    fcode <= c;
    @(posedge clk);
    fire <= 1'h0;
    n = 0;
    while (cpu_int[15:1] === 15'h0 && n < 8) begin
      @(posedge clk);
      n++;
    end
    chk(32'(cpu_int), 32'h1 << ln);
    repeat (6) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      end_sim;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    rd(`ADDR_SELECT_HIGH, {1'h0, 5'h02, 5'h01, 5'h00, 1'h0, 5'h0B, 5'h0A, 5'h03}, 2'h0);
    rd(`ADDR_SELECT_LOW, {1'h0, 5'h09, 5'h08, 5'h07, 1'h0, 5'h06, 5'h05, 5'h04}, 2'h0);
    rd(32'h019C0020, 32'h0, 2'h2);
    wr(32'h019C0020, 32'h1, 2'h2);
    for (int i = 4; i < 16; i++) route(i, dflt[i]);
    chk(32'(irq), 32'h0);
    wr(`ADDR_EDGE_POLARITY, 32'hF, 2'h0);
    route(4, 5'h04);
    wr(`ADDR_SELECT_LOW, {1'h1, 5'h12, 5'h11, 5'h0F, 1'h1, 5'h0E, 5'h0D, 5'h0C}, 2'h0);
    rd(`ADDR_SELECT_LOW, {1'h0, 5'h12, 5'h11, 5'h0F, 1'h0, 5'h0E, 5'h0D, 5'h0C}, 2'h0);
    for (int i = 4; i < 10; i++) route(i, smap[i]);
    route(1, 5'h00);
    wr(`ADDR_IRQ_STATUS, 32'hFFFF, 2'h0);
    wr(`ADDR_IRQ_MASK, 32'h2000, 2'h0);
    route(13, 5'h00);
    chk(32'(irq), 32'h1);
    rd(`ADDR_IRQ_STATUS, 32'h2000, 2'h0);
    wr(`ADDR_IRQ_STATUS, 32'h2000, 2'h0);
    chk(32'(irq), 32'h0);
    end_sim;
  end
endmodule // testbench
